// *** rcf_top.sv ***
// reset cause flags, return stack and AXI4-Lite register slave
// How it works
// R1: 16-entry 15-bit return stack flags pushes when full, pops when empty
// R2: stack errors always set their flag; reset pulse only when enabled
// R3: bit 7 set by overflow, cleared only by firmware, power-on or brown-out
// R4: bit 6 set by underflow, cleared only by firmware, power-on or brown-out
// R5: bit 4 goes low on watchdog reset, otherwise holds until firmware, power-on or brown-out sets it
// R6: bit 3 goes low on external clear pin reset
// R7: bit 2 goes low when the reset instruction executes
// R8: bit 1 reads low after power-on; firmware writes it high
// R9: bit 0 low after brown-out or power-on; firmware writes it high
// R10: every implemented flag writable; value held until hardware changes it
// R11: power-on/brown-out initial values; other resets leave flags; bit 5 zero
// R12: flags survive the reset they record, readable straight after
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module rcf_top (
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   // AXI4-Lite slave
   input  wire logic [7:0]              s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [7:0]              s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   // reset causes from the rest of the device
   input  rcf_pkg::rcf_cause_type       cause,
   // core return stack port
   input  rcf_pkg::rcf_stk_req_type     stk_req,
   output rcf_pkg::rcf_stk_rsp_type     stk_rsp,
   output logic                         sw_reset_r,
   output logic                         irq_r
);
   import rcf_pkg::*;

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [7:0]         status_r;
   logic [7:0]         status_nxt;
   logic               stk_rst_en_r;
   logic [IRQ_W-1:0]   irq_st_r;
   logic [IRQ_W-1:0]   irq_st_nxt;
   logic [IRQ_W-1:0]   irq_mk_r;
   logic               aw_held_r;
   logic               w_held_r;
   logic [7:0]         aw_addr_r;
   logic [31:0]        w_data_r;
   logic [3:0]         w_strb_r;
   logic               wr_fire;
   logic               ar_fire;
   logic [31:0]        rd_word;
   logic               rd_hit;
   logic               wr_hit;
   logic               wr_status;
   logic               wr_ctrl;
   logic               wr_irq_st;
   logic               wr_irq_mk;
   logic [7:0]         wbyte;
   logic               any_cause;
   logic               stk_err;
   logic               flush;
   logic               mem_we;
   logic               mem_re;
   logic [STK_AW-1:0]  mem_waddr;
   logic [STK_AW-1:0]  mem_raddr;
   logic               pop_done;
   logic               ovf_ev;
   logic               unf_ev;
   logic [STK_CW-1:0]  stk_count;
   logic [STK_WIDTH-1:0] pop_data;

   // true when an address names one of the five registers
   function automatic logic addr_mapped(input logic [7:0] a);
      return (a == ADDR_STATUS) || (a == ADDR_CTRL) ||
             (a == ADDR_IRQ_ST) || (a == ADDR_IRQ_MK) ||
             (a == ADDR_DEPTH);
   endfunction : addr_mapped

   // ------------------------------------------------------------
   // return stack
   // ------------------------------------------------------------
   rcf_stack_ctl u_ctl (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .flush      (flush),
      .req        (stk_req),
      .we         (mem_we),
      .re         (mem_re),
      .waddr      (mem_waddr),
      .raddr      (mem_raddr),
      .pop_done_r (pop_done),
      .ovf_ev     (ovf_ev),
      .unf_ev     (unf_ev),
      .count_r    (stk_count)
   );

   rcf_stack_mem u_mem (
      .aclk    (aclk),
      .we      (mem_we),
      .waddr   (mem_waddr),
      .wdata   (stk_req.data),
      .re      (mem_re),
      .raddr   (mem_raddr),
      .rdata_r (pop_data)
   );

   // both fields come from flops in the stack modules
   assign stk_rsp = '{valid: pop_done, data: pop_data};

   // ------------------------------------------------------------
   // reset events
   // ------------------------------------------------------------
   // R1: stack error detection
   assign stk_err   = ovf_ev | unf_ev;
   assign any_cause = cause.bor | cause.wdt | cause.clr_pin |
                      cause.reset_instr;
   // any recorded reset, or our own stack reset, empties the stack
   assign flush     = any_cause | sw_reset_r;

   // R2: reset request only when enabled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sw_reset_r <= 1'b0;
      end else begin
         sw_reset_r <= stk_err & stk_rst_en_r;
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------
   // address and data are latched independently, in either order
   assign wr_fire = aw_held_r & w_held_r & ~s_axi_bvalid;
   assign wr_hit  = addr_mapped(aw_addr_r);
   assign wbyte   = w_strb_r[0] ? w_data_r[7:0] : 8'h00;
   assign wr_status = wr_fire & w_strb_r[0] &
                      (aw_addr_r == ADDR_STATUS);
   assign wr_ctrl   = wr_fire & w_strb_r[0] &
                      (aw_addr_r == ADDR_CTRL);
   assign wr_irq_st = wr_fire & w_strb_r[0] &
                      (aw_addr_r == ADDR_IRQ_ST);
   assign wr_irq_mk = wr_fire & w_strb_r[0] &
                      (aw_addr_r == ADDR_IRQ_MK);

   // address holder
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r     <= 1'b0;
         aw_addr_r     <= 8'h00;
         s_axi_awready <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held_r <= 1'b0;
         end
         s_axi_awready <= ~aw_held_r & ~s_axi_awready &
                          s_axi_awvalid;
      end
   end

   // data holder
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_r     <= 1'b0;
         w_data_r     <= 32'h0000_0000;
         w_strb_r     <= 4'h0;
         s_axi_wready <= 1'b0;
      end else begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held_r <= 1'b0;
         end
         s_axi_wready <= ~w_held_r & ~s_axi_wready & s_axi_wvalid;
      end
   end

   // write response; unmapped address answers SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------
   assign ar_fire = s_axi_arvalid & s_axi_arready;
   assign rd_hit  = addr_mapped(s_axi_araddr);

   // read mux; bits above each field read zero
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (s_axi_araddr)
         ADDR_STATUS: rd_word[7:0] = status_r & STATUS_IMPL;
         ADDR_CTRL:   rd_word[BIT_STK_RST_EN] = stk_rst_en_r;
         ADDR_IRQ_ST: rd_word[IRQ_W-1:0] = irq_st_r;
         ADDR_IRQ_MK: rd_word[IRQ_W-1:0] = irq_mk_r;
         ADDR_DEPTH:  rd_word[STK_CW-1:0] = stk_count;
         default:     rd_word = 32'h0000_0000;
      endcase
   end

   // one read in flight; arready drops while the answer waits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready &
                          s_axi_arvalid;
         if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // reset cause status
   // ------------------------------------------------------------
   // firmware write first, hardware events after so they win
   always_comb begin
      status_nxt = status_r;
      // R10: firmware may write every implemented flag
      if (wr_status) begin
         status_nxt = wbyte;
      end
      // R9: brown-out lowers its flag
      // R11: brown-out reinitialises, keeps the power-on bit
      if (cause.bor) begin
         status_nxt = STATUS_BOR;
         status_nxt[BIT_POR] = status_r[BIT_POR];
      end
      // R3: overflow sets its flag
      if (ovf_ev) begin
         status_nxt[BIT_OVF] = 1'b1;
      end
      // R4: underflow sets its flag
      if (unf_ev) begin
         status_nxt[BIT_UNF] = 1'b1;
      end
      // R5: watchdog reset pulls its flag low
      if (cause.wdt) begin
         status_nxt[BIT_WDT] = 1'b0;
      end
      // R6: clear pin reset pulls its flag low
      if (cause.clr_pin) begin
         status_nxt[BIT_CLR] = 1'b0;
      end
      // R7: reset instruction pulls its flag low
      if (cause.reset_instr) begin
         status_nxt[BIT_RI] = 1'b0;
      end
      // R11: bit 5 never stores a one
      status_nxt = status_nxt & STATUS_IMPL;
   end

   // R12: only power-on reloads; recorded resets pass through
   // R8: power-on leaves por and bor low
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_r <= STATUS_POR;
      end else begin
         status_r <= status_nxt;
      end
   end

   // ------------------------------------------------------------
   // control and interrupts
   // ------------------------------------------------------------
   // event set beats a write-one clear in the same cycle
   assign irq_st_nxt = (irq_st_r &
                        ~(wr_irq_st ? wbyte[IRQ_W-1:0] : '0)) |
                       {ovf_ev, unf_ev};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stk_rst_en_r <= 1'b0;
         irq_st_r     <= '0;
         irq_mk_r     <= '0;
         irq_r        <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            stk_rst_en_r <= wbyte[BIT_STK_RST_EN];
         end
         if (wr_irq_mk) begin
            irq_mk_r <= wbyte[IRQ_W-1:0];
         end
         irq_st_r <= irq_st_nxt;
         irq_r    <= |(irq_st_nxt & irq_mk_r);
      end
   end

endmodule : rcf_top

// *** rcf_pkg.sv ***
// constants and carrier types for the reset cause flag block
package rcf_pkg;

   // ------------------------------------------------------------
   // stack geometry
   // ------------------------------------------------------------
   localparam int STK_DEPTH = 16;
   localparam int STK_WIDTH = 15;
   localparam int STK_AW    = 4;
   localparam int STK_CW    = 5;

   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CTRL   = 8'h04;
   localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MK = 8'h0C;
   localparam logic [7:0] ADDR_DEPTH  = 8'h10;

   // ------------------------------------------------------------
   // reset cause status fields
   // ------------------------------------------------------------
   localparam int BIT_OVF = 7;
   localparam int BIT_UNF = 6;
   localparam int BIT_WDT = 4;
   localparam int BIT_CLR = 3;
   localparam int BIT_RI  = 2;
   localparam int BIT_POR = 1;
   localparam int BIT_BOR = 0;
   localparam logic [7:0] STATUS_IMPL = 8'hDF;
   // power-on value: por and bor low, others idle
   localparam logic [7:0] STATUS_POR  = 8'h1C;
   // brown-out keeps por bit, lowers bor bit
   localparam logic [7:0] STATUS_BOR  = 8'h1E;
   localparam int BIT_STK_RST_EN = 0;
   localparam int IRQ_W = 2;
   localparam int IRQ_OVF = 1;
   localparam int IRQ_UNF = 0;

   // AXI4-Lite response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic                 push;
      logic                 pop;
      logic [STK_WIDTH-1:0] data;
   } rcf_stk_req_type;

   typedef struct packed {
      logic                 valid;
      logic [STK_WIDTH-1:0] data;
   } rcf_stk_rsp_type;

   typedef struct packed {
      logic bor;
      logic wdt;
      logic clr_pin;
      logic reset_instr;
   } rcf_cause_type;

endpackage : rcf_pkg

// *** rcf_stack_mem.sv ***
// return stack storage with registered read data
`timescale 1ns/1ps
module rcf_stack_mem #(
   parameter int WIDTH = rcf_pkg::STK_WIDTH,
   parameter int DEPTH = rcf_pkg::STK_DEPTH,
   parameter int AW    = rcf_pkg::STK_AW
) (
   input  wire logic             aclk,
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic             re,
   input  wire logic [AW-1:0]    raddr,
   output logic      [WIDTH-1:0] rdata_r
);
   import rcf_pkg::*;

   logic [WIDTH-1:0] mem [DEPTH];

   // storage has no reset: contents only matter once pushed
   always_ff @(posedge aclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // read port, held between pops
   always_ff @(posedge aclk) begin
      if (re) begin
         rdata_r <= mem[raddr];
      end
   end

endmodule : rcf_stack_mem

// *** rcf_stack_ctl.sv ***
// return stack pointer, fill count and error detection
`timescale 1ns/1ps
module rcf_stack_ctl #(
   parameter int DEPTH = rcf_pkg::STK_DEPTH,
   parameter int AW    = rcf_pkg::STK_AW,
   parameter int CW    = rcf_pkg::STK_CW
) (
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   input  wire logic                     flush,
   input  rcf_pkg::rcf_stk_req_type      req,
   output logic                          we,
   output logic                          re,
   output logic      [AW-1:0]            waddr,
   output logic      [AW-1:0]            raddr,
   output logic                          pop_done_r,
   output logic                          ovf_ev,
   output logic                          unf_ev,
   output logic      [CW-1:0]            count_r
);
   import rcf_pkg::*;

   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   localparam logic [CW-1:0] ONE  = CW'(1);

   logic          is_full;
   logic          is_empty;
   logic          do_pop;
   logic          do_push;
   logic [CW-1:0] count_nxt;

   // pop wins when both arrive together
   assign do_pop   = req.pop;
   assign do_push  = req.push & ~req.pop;
   assign is_full  = (count_r == FULL);
   assign is_empty = (count_r == '0);
   // R1: overflow and underflow
   assign ovf_ev   = do_push & is_full;
   assign unf_ev   = do_pop & is_empty;
   assign we       = do_push & ~is_full;
   assign re       = do_pop;
   assign waddr    = count_r[AW-1:0];
   // empty pop wraps to the top entry, like a circular stack
   assign raddr    = AW'(count_r - ONE);

   always_comb begin
      count_nxt = count_r;
      if (do_pop && !is_empty) begin
         count_nxt = count_r - ONE;
      end else if (we) begin
         count_nxt = count_r + ONE;
      end
   end

   // fill count; a recorded reset empties the stack
   always_ff @(posedge aclk) begin
      if (!aresetn || flush) begin
         count_r    <= '0;
         pop_done_r <= 1'b0;
      end else begin
         count_r    <= count_nxt;
         pop_done_r <= do_pop;
      end
   end

endmodule : rcf_stack_ctl

// *** rcf_properties.sv ***
// port-level assertions for the reset cause flag block
`timescale 1ns/1ps
module rcf_properties (
   input wire logic                 aclk,
   input wire logic                 aresetn,
   input wire logic                 s_axi_awready,
   input wire logic                 s_axi_wvalid,
   input wire logic                 s_axi_wready,
   input wire logic [1:0]           s_axi_bresp,
   input wire logic                 s_axi_bvalid,
   input wire logic                 s_axi_bready,
   input wire logic                 s_axi_arvalid,
   input wire logic                 s_axi_arready,
   input wire logic [31:0]          s_axi_rdata,
   input wire logic                 s_axi_rvalid,
   input wire logic                 s_axi_rready,
   input rcf_pkg::rcf_stk_req_type  stk_req,
   input rcf_pkg::rcf_stk_rsp_type  stk_rsp,
   input wire logic                 sw_reset_r
);
   import rcf_pkg::*;
   // one clock domain, reset ends every attempt
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_rsp_pop; stk_req.pop |=> stk_rsp.valid; endproperty
   a_rsp_pop: assert property (p_rsp_pop) else $error("pop lost");
   property p_rsp_cause; stk_rsp.valid |-> $past(stk_req.pop); endproperty
   a_rsp_cause: assert property (p_rsp_cause) else $error("stray data");
   property p_sw_pulse; sw_reset_r |=> !sw_reset_r; endproperty
   a_sw_pulse: assert property (p_sw_pulse) else $error("long reset");
   property p_aw_pulse; s_axi_awready |=> !s_axi_awready; endproperty
   a_aw_pulse: assert property (p_aw_pulse) else $error("awready held");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
   property p_b_after_w; s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid;
   endproperty
   a_b_after_w: assert property (p_b_after_w) else $error("no bvalid");
   property p_r_after_ar; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_after_ar: assert property (p_r_after_ar) else $error("no rvalid");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("rdata moved");
   property p_r_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
   a_r_upper: assert property (p_r_upper) else $error("upper bits set");
endmodule : rcf_properties

bind rcf_top rcf_properties i_rcf_properties (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .stk_req(stk_req), .stk_rsp(stk_rsp), .sw_reset_r(sw_reset_r)
);

// *** testbench.sv ***
// self-checking bench for the reset cause flag block
`timescale 1ns/1ps
module testbench;
   import rcf_pkg::*;
   typedef struct packed {
      logic [7:0]  wa;
      logic [31:0] wd;
      logic [3:0]  ws;
      logic [1:0]  br;
      logic [7:0]  ra;
      logic [31:0] rd;
      logic [1:0]  rr;
   } rcf_row_type;
   logic            aclk = 1'h0;
   logic            aresetn = 1'h0;
   logic [7:0]      awaddr = 8'h00;
   logic [7:0]      araddr = 8'h00;
   logic [31:0]     wdata = 32'h0;
   logic [3:0]      wstrb = 4'h0;
   logic            awvalid = 1'h0;
   logic            wvalid = 1'h0;
   logic            bready = 1'h0;
   logic            arvalid = 1'h0;
   logic            rready = 1'h0;
   logic            slow = 1'h0;
   logic            awready, wready, bvalid, arready, rvalid, sw_reset_r, irq_r;
   logic [1:0]      bresp, rresp, resp;
   logic [31:0]     rdata, val;
   logic [7:0]      st;
   rcf_cause_type   cause = '0;
   rcf_stk_req_type stk_req = '0;
   rcf_stk_rsp_type stk_rsp;
   int              bad_count = 0;
   int              check_count = 0;
   int              sw_count = 0;
   // ordinary register cases: write, then read back
   rcf_row_type rows [8] = '{
      '{ADDR_STATUS, 32'hFF, 4'hF, RESP_OKAY, ADDR_STATUS, 32'hDF, RESP_OKAY},
      '{ADDR_STATUS, 32'h00, 4'hF, RESP_OKAY, ADDR_STATUS, 32'h00, RESP_OKAY},
      '{ADDR_STATUS, 32'h5A, 4'h0, RESP_OKAY, ADDR_STATUS, 32'h00, RESP_OKAY},
      '{ADDR_STATUS, 32'h1F, 4'h1, RESP_OKAY, ADDR_STATUS, 32'h1F, RESP_OKAY},
      '{8'h14, 32'hFF, 4'hF, RESP_SLVERR, 8'h14, 32'h00, RESP_SLVERR},
      '{ADDR_CTRL, 32'h01, 4'hF, RESP_OKAY, ADDR_CTRL, 32'h01, RESP_OKAY},
      '{ADDR_CTRL, 32'h00, 4'hF, RESP_OKAY, ADDR_CTRL, 32'h00, RESP_OKAY},
      '{ADDR_IRQ_MK, 32'h00, 4'hF, RESP_OKAY, ADDR_DEPTH, 32'h00, RESP_OKAY}};

   rcf_top i_rcf_top (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .cause(cause), .stk_req(stk_req),
      .stk_rsp(stk_rsp), .sw_reset_r(sw_reset_r), .irq_r(irq_r));

   // 250 MHz clock
   initial begin
      forever #2 aclk = ~aclk;
   end
   // count reset requests so missing or extra pulses show
   always @(posedge aclk) begin
      if (sw_reset_r === 1'h1) sw_count <= sw_count + 1;
   end

   task automatic check(input string name, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done

   // a wait ran out: counted, then the run closes
   task automatic hung;
      bad_count++;
      $display("[FAIL] handshake expected done seen timeout");
      test_done();
   endtask : hung

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         input logic [3:0] s);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= ~slow;
      do begin
         @(posedge aclk);
         n++;
         if (awready === 1'h1) awvalid <= 1'h0;
         if (wready === 1'h1) wvalid <= 1'h0;
         if (n == 4 && slow) bready <= 1'h1;
      end while ((bvalid & bready) !== 1'h1 && n < 50);
      if (n >= 50) hung();
      resp = bresp;
      bready <= 1'h0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= ~slow;
      do begin
         @(posedge aclk);
         n++;
         if (arready === 1'h1) arvalid <= 1'h0;
         if (n == 4 && slow) rready <= 1'h1;
      end while ((rvalid & rready) !== 1'h1 && n < 50);
      if (n >= 50) hung();
      val = rdata;
      resp = rresp;
      rready <= 1'h0;
   endtask : axi_rd

   // one-cycle stack request, then look once the answer has landed
   task automatic stk_op(input logic push, pop, input logic [14:0] d);
      @(posedge aclk);
      stk_req <= '{push, pop, d};
      @(posedge aclk);
      stk_req <= '0;
      #1;
   endtask : stk_op

   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      axi_rd(ADDR_STATUS);
      check("status after reset", val, 32'h1C);
      foreach (rows[i]) begin
         axi_wr(rows[i].wa, rows[i].wd, rows[i].ws);
         check("bresp", resp, rows[i].br);
         axi_rd(rows[i].ra);
         check("rdata", val, rows[i].rd);
         check("rresp", resp, rows[i].rr);
      end
      // fill past full: one push refused and flagged
      for (int i = 0; i < 17; i++) stk_op(1'h1, 1'h0, 15'(15'h7000 + i));
      axi_rd(ADDR_DEPTH);
      check("depth when full", val, 32'h10);
      axi_rd(ADDR_STATUS);
      check("status after overflow", val, 32'h9F);
      check("reset requests", sw_count, 32'h0);
      axi_rd(ADDR_IRQ_ST);
      check("irq status", val, 32'h2);
      check("irq masked", irq_r, 32'h0);
      axi_wr(ADDR_IRQ_MK, 32'h3, 4'hF);
      axi_rd(ADDR_IRQ_MK);
      check("irq mask", val, 32'h3);
      check("irq unmasked", irq_r, 32'h1);
      // drain: last in comes out first, then one pop too many
      for (int i = 15; i >= 0; i--) begin
         stk_op(1'h0, 1'h1, 15'h0);
         check("pop valid", stk_rsp.valid, 32'h1);
         check("pop data", stk_rsp.data, 32'(15'h7000 + i));
      end
      stk_op(1'h0, 1'h1, 15'h0);
      axi_rd(ADDR_STATUS);
      check("status after underflow", val, 32'hDF);
      axi_wr(ADDR_IRQ_ST, 32'h3, 4'hF);
      axi_rd(ADDR_IRQ_ST);
      check("irq status cleared", val, 32'h0);
      check("irq after clear", irq_r, 32'h0);
      axi_wr(ADDR_STATUS, 32'h1F, 4'hF);
      axi_rd(ADDR_STATUS);
      check("stack flags cleared", val, 32'h1F);
      // watchdog, clear pin and reset instruction each lower only their own flag, which survives; brown-out then reinitialises
      st = 8'h1F;
      for (int i = 0; i < 3; i++) begin
         @(posedge aclk);
         cause <= rcf_cause_type'(4'h4 >> i);
         @(posedge aclk);
         cause <= '0;
         st = st & ~(8'h10 >> i);
         axi_rd(ADDR_STATUS);
         check("status after cause", val, {24'h0, st});
      end
      @(posedge aclk);
      cause <= rcf_cause_type'(4'h8);
      @(posedge aclk);
      cause <= '0;
      axi_rd(ADDR_STATUS);
      check("status after brown-out", val, 32'h1E);
      // with resets enabled a stack error requests one reset
      axi_wr(ADDR_CTRL, 32'h1, 4'hF);
      stk_op(1'h0, 1'h1, 15'h0);
      axi_rd(ADDR_STATUS);
      check("status after error reset", val, 32'h5E);
      check("reset requests", sw_count, 32'h1);
      // late ready: each answer must stand until taken
      slow = 1'h1;
      axi_wr(ADDR_IRQ_MK, 32'h1, 4'hF);
      check("late bresp", resp, RESP_OKAY);
      axi_rd(ADDR_IRQ_MK);
      check("late rdata", val, 32'h1);
      slow = 1'h0;
      // second power-on in mid-run
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      axi_rd(ADDR_STATUS);
      check("status after power-on", val, 32'h1C);
      axi_rd(ADDR_CTRL);
      check("ctrl after power-on", val, 32'h0);
      check("irq after power-on", irq_r, 32'h0);
      test_done();
   end
endmodule : testbench
